// ===== logic/der_pkg.sv
// Constants and types for the downstream error reporting block
package der_pkg;
  // Register byte offsets
  localparam logic [7:0] DER_CTRL_OFS = 8'h00;
  localparam logic [7:0] DER_SEV_OFS  = 8'h04;
  localparam logic [7:0] DER_MASK_OFS = 8'h08;
  localparam logic [7:0] DER_STAT_OFS = 8'h0C;
  localparam logic [7:0] DER_FEP_OFS  = 8'h10;
  localparam logic [7:0] DER_HDR_OFS  = 8'h14;
  localparam logic [7:0] DER_SHDR_OFS = 8'h18;
  // Control bits
  localparam int C_SERR = 0;
  localparam int C_FTL  = 1;
  localparam int C_NFTL = 2;
  localparam int C_COR  = 3;
  localparam int C_PPER = 4;
  localparam int C_SPER = 5;
  localparam int CTRL_W = 6;
  // Severity bits, one means fatal
  localparam int SV_POISONED_PACKET_STATUS = 0;
  localparam int SV_ECRC = 1;
  localparam int SV_TLPE = 2;
  localparam int SEV_W   = 3;
  // Mask bits
  localparam int MK_POISONED_PACKET_STATUS = 0;
  localparam int MK_ECRC = 1;
  localparam int MK_TLPE = 2;
  localparam int MK_ADVISORY_NONFATAL_FLAG = 3;
  localparam int MK_PERR = 4;
  localparam int MASK_W  = 5;
  // Status bits
  localparam int ST_DPE  = 0;
  localparam int ST_PMDP = 1;
  localparam int ST_SSE  = 2;
  localparam int ST_COR  = 3;
  localparam int ST_FTL  = 4;
  localparam int ST_NFTL = 5;
  localparam int ST_ADVISORY_NONFATAL_FLAG = 6;
  localparam int ST_POISONED_PACKET_STATUS = 7;
  localparam int ST_ECRC = 8;
  localparam int ST_TLPE = 9;
  localparam int ST_SMDP = 10;
  localparam int ST_PERR = 11;
  localparam int ST_W    = 12;
  // First error pointer register layout
  localparam int FEP_PTR_LSB  = 0;
  localparam int FEP_VLD      = 7;
  localparam int FEP_SPTR_LSB = 8;
  localparam int FEP_SVLD     = 15;
  localparam int PTR_W        = 5;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [SEV_W-1:0]  SEV_RST  = 3'h0;
  localparam logic [MASK_W-1:0] MASK_RST = 5'h00;
  // Error message codes
  localparam logic [1:0] MSG_NONE = 2'h0;
  localparam logic [1:0] MSG_COR  = 2'h1;
  localparam logic [1:0] MSG_NFTL = 2'h2;
  localparam logic [1:0] MSG_FTL  = 2'h3;
  // Immediate PCI/X termination kinds
  localparam logic [1:0] IMM_OK     = 2'h0;
  localparam logic [1:0] IMM_DERR   = 2'h1;
  localparam logic [1:0] IMM_MABORT = 2'h2;
  localparam logic [1:0] IMM_TABORT = 2'h3;
  // Completion status codes, then the word transfer size
  localparam logic [2:0] CPL_SC = 3'h0;
  localparam logic [2:0] CPL_UR = 3'h1;
  localparam logic [2:0] CPL_CA = 3'h4;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DATA = 1'b1
  } der_bus_t;
endpackage

// ===== logic/der_top.sv
// Downstream error detection, logging and reporting with AHB-Lite registers
`timescale 1ns/1ps
module der_top
  import der_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int HDR_W  = 32
) (
  input  wire logic              ref_clk,          // Core clock
  input  wire logic              rst,              // Synchronous reset
  input  wire logic              hsel,             // Slave select
  input  wire logic [ADDR_W-1:0] haddr,            // Byte address
  input  wire logic [1:0]        htrans,           // Transfer type
  input  wire logic              hwrite,           // Write
  input  wire logic [2:0]        hsize,            // Transfer size
  input  wire logic              hready,           // Bus ready
  input  wire logic [31:0]       hwdata,           // Write data
  output logic      [31:0]       hrdata,           // Read data
  output logic                   hreadyout,        // Slave ready
  output logic                   hresp,            // Response, always OKAY
  input  wire logic              rx_valid,         // Received TLP pulse
  input  wire logic              rx_poisoned,      // TLP poisoned
  input  wire logic              rx_crc_err,       // TLP failed ECRC
  input  wire logic              rx_is_write,      // TLP is a write request
  input  wire logic              rx_is_rdcpl,      // TLP is a read completion
  input  wire logic [HDR_W-1:0]  rx_hdr,           // TLP header word
  input  wire logic              adv_err,          // Advisory error pulse
  input  wire logic [HDR_W-1:0]  adv_hdr,          // Its header word
  input  wire logic              fwd_done,         // Forwarded transfer ended
  input  wire logic              parity_error_pin_n, // PCI/X parity pin
  input  wire logic              imm_done,         // Immediate termination
  input  wire logic [1:0]        imm_kind,         // Termination kind
  input  wire logic              imm_is_read,      // Terminated request is read
  output logic                   fwd_accept,       // Forward TLP pulse
  output logic                   fwd_drop,         // Drop TLP pulse
  output logic                   fwd_parity_invert, // Invert data parity
  output logic                   cpl_valid,        // Completion pulse
  output logic      [2:0]        cpl_status,       // Completion status
  output logic                   cpl_poison,       // Completion poisoned
  output logic                   msg_valid,        // Error message pulse
  output logic      [1:0]        msg_type          // Message kind
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic [CTRL_W-1:0] ctrl_reg;
  logic [SEV_W-1:0]  sev_reg;
  logic [MASK_W-1:0] mask_reg;
  logic [ST_W-1:0]   stat_reg;
  logic [ST_W-1:0]   stat_next;
  logic [PTR_W-1:0]  ptr_reg;
  logic              ptr_vld_reg;
  logic [PTR_W-1:0]  sptr_reg;
  logic              sptr_vld_reg;
  logic [HDR_W-1:0]  hdr_reg;
  logic [HDR_W-1:0]  shdr_reg;
  logic [HDR_W-1:0]  fwd_hdr_reg;
  logic              fwd_active_reg;
  logic              fwd_write_reg;
  logic [2:0]        perr_sync_reg;
  logic              perr_level_reg;
  der_bus_t          bus_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              wr_reg;

  // ************************************************************
  // Bus decode
  // ************************************************************
  // Full compare, so aliases above the map read as unmapped
  function automatic logic ofs_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    ofs_hit = (a == ADDR_W'(ofs));
  endfunction

  wire logic hit_ctrl = ofs_hit(addr_reg, DER_CTRL_OFS);
  wire logic hit_sev  = ofs_hit(addr_reg, DER_SEV_OFS);
  wire logic hit_mask = ofs_hit(addr_reg, DER_MASK_OFS);
  wire logic hit_stat = ofs_hit(addr_reg, DER_STAT_OFS);
  wire logic hit_fep  = ofs_hit(addr_reg, DER_FEP_OFS);
  wire logic hit_hdr  = ofs_hit(addr_reg, DER_HDR_OFS);
  wire logic hit_shdr = ofs_hit(addr_reg, DER_SHDR_OFS);

  wire logic take = hsel & hready & htrans[1];
  wire logic do_wr = (bus_reg == BUS_DATA) & wr_reg;
  wire logic wr_ctrl = do_wr & hit_ctrl;
  wire logic wr_sev  = do_wr & hit_sev;
  wire logic wr_mask = do_wr & hit_mask;
  wire logic wr_stat = do_wr & hit_stat;
  wire logic wr_fep  = do_wr & hit_fep;
  wire logic [ST_W-1:0] stat_clr = wr_stat ? hwdata[ST_W-1:0] : '0;
  wire logic ptr_clr  = wr_fep & hwdata[FEP_VLD];
  wire logic sptr_clr = wr_fep & hwdata[FEP_SVLD];

  wire logic [31:0] fep_word = {16'h0000, sptr_vld_reg, 2'h0, sptr_reg,
                                ptr_vld_reg, 2'h0, ptr_reg};
  wire logic [31:0] rd_word =
    hit_ctrl ? {{(32-CTRL_W){1'b0}}, ctrl_reg} :
    hit_sev  ? {{(32-SEV_W){1'b0}}, sev_reg} :
    hit_mask ? {{(32-MASK_W){1'b0}}, mask_reg} :
    hit_stat ? {{(32-ST_W){1'b0}}, stat_reg} :
    hit_fep  ? fep_word :
    hit_hdr  ? hdr_reg :
    hit_shdr ? shdr_reg : 32'h0000_0000;

  // ************************************************************
  // Enables and classification
  // ************************************************************
  wire logic system_error_enable = ctrl_reg[C_SERR];
  wire logic ftl_en  = ctrl_reg[C_FTL] | system_error_enable;
  wire logic nftl_en = ctrl_reg[C_NFTL] | system_error_enable;
  wire logic cor_en  = ctrl_reg[C_COR];
  wire logic advisory_nonfatal_flag_mk = mask_reg[MK_ADVISORY_NONFATAL_FLAG];

  // CRC wins over poison: a dropped packet is never forwarded
  wire logic crc = rx_valid & rx_crc_err;
  wire logic poi = rx_valid & rx_poisoned & ~rx_crc_err;

  // Poisoned packets
  wire logic p_nf   = poi & ~sev_reg[SV_POISONED_PACKET_STATUS];
  wire logic p_adv  = p_nf & ~advisory_nonfatal_flag_mk;
  wire logic p_advm = p_nf & advisory_nonfatal_flag_mk;
  wire logic p_ftl  = poi & sev_reg[SV_POISONED_PACKET_STATUS];
  wire logic p_log  = (p_adv | p_ftl) & ~mask_reg[MK_POISONED_PACKET_STATUS];
  wire logic p_cmsg = p_adv & cor_en;
  wire logic p_fmsg = p_ftl & ~mask_reg[MK_POISONED_PACKET_STATUS] & ftl_en;

  // End-to-end CRC errors
  wire logic c_f    = sev_reg[SV_ECRC];
  wire logic c_log  = crc & ~mask_reg[MK_ECRC];
  wire logic c_fmsg = c_log & c_f & ftl_en;
  wire logic c_nmsg = c_log & ~c_f & nftl_en;

  // Generic advisory errors; a fatal severity takes the plain path
  wire logic a_nf   = adv_err & ~sev_reg[SV_TLPE];
  wire logic a_un   = a_nf & ~advisory_nonfatal_flag_mk;
  wire logic a_ftl  = adv_err & sev_reg[SV_TLPE];
  wire logic a_log  = (a_un | a_ftl) & ~mask_reg[MK_TLPE];
  wire logic a_cmsg = a_un & cor_en;
  wire logic a_fmsg = a_ftl & ~mask_reg[MK_TLPE] & ftl_en;

  // Parity pin seen while a poisoned write goes out with bad parity
  // Level moves only when the last two stages agree, so a one-cycle
  // glitch on the pin is never seen
  wire logic perr_now  = (perr_sync_reg[1] == perr_sync_reg[2]) ?
                         ~perr_sync_reg[2] : perr_level_reg;
  wire logic perr_rise = perr_now & ~perr_level_reg;
  wire logic perr_hit  = perr_rise & fwd_active_reg & fwd_parity_invert
                         & fwd_write_reg;
  wire logic s_log     = perr_hit & ~mask_reg[MK_PERR] & ~sptr_vld_reg;

  // ************************************************************
  // Status set vector
  // ************************************************************
  wire logic any_fmsg = p_fmsg | c_fmsg | a_fmsg;
  wire logic any_nmsg = c_nmsg;
  wire logic any_cmsg = p_cmsg | a_cmsg;
  logic [ST_W-1:0] stat_set;
  always_comb begin
    stat_set = '0;
    stat_set[ST_DPE]  = poi | crc;
    stat_set[ST_PMDP] = poi & rx_is_rdcpl & ctrl_reg[C_PPER];
    stat_set[ST_SSE]  = (any_fmsg | any_nmsg) & system_error_enable;
    stat_set[ST_COR]  = p_adv | p_advm | a_nf;
    stat_set[ST_FTL]  = p_ftl | (crc & c_f) | a_ftl;
    stat_set[ST_NFTL] = crc & ~c_f;
    stat_set[ST_ADVISORY_NONFATAL_FLAG] = p_adv | p_advm | a_nf;
    stat_set[ST_POISONED_PACKET_STATUS] = p_adv | p_ftl;
    stat_set[ST_ECRC] = crc;
    stat_set[ST_TLPE] = a_un | a_ftl;
    stat_set[ST_SMDP] = perr_hit & ctrl_reg[C_SPER];
    stat_set[ST_PERR] = perr_hit;
  end
  // Set wins over a same-cycle clear
  assign stat_next = (stat_reg & ~stat_clr) | stat_set;

  // ************************************************************
  // Header logging under the first error pointer
  // ************************************************************
  // Received packet takes the pointer before a same-cycle advisory error
  wire logic log_take = (p_log | c_log | a_log) & ~ptr_vld_reg;
  wire logic [HDR_W-1:0] log_hdr = (p_log | c_log) ? rx_hdr : adv_hdr;
  wire logic [PTR_W-1:0] log_ptr =
    p_log ? PTR_W'(ST_POISONED_PACKET_STATUS) : (c_log ? PTR_W'(ST_ECRC) : PTR_W'(ST_TLPE));

  // ************************************************************
  // Completion translation
  // ************************************************************
  // A write cannot carry poison back, so its data error is refused
  wire logic [2:0] imm_status =
    (imm_kind == IMM_MABORT) ? CPL_UR :
    (imm_kind == IMM_TABORT) ? CPL_CA :
    ((imm_kind == IMM_DERR) & ~imm_is_read) ? CPL_UR : CPL_SC;
  wire logic imm_poison = (imm_kind == IMM_DERR) & imm_is_read;

  // ************************************************************
  // Message selection, fatal first when events coincide
  // ************************************************************
  // Parity pin reports add no cause here, so they never raise a message
  wire logic [1:0] msg_sel = any_fmsg ? MSG_FTL :
                             any_nmsg ? MSG_NFTL :
                             any_cmsg ? MSG_COR : MSG_NONE;

  // ************************************************************
  // Bus slave, one wait state so read data leaves a flip-flop
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_reg   <= BUS_IDLE;
      addr_reg  <= '0;
      wr_reg    <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      case (bus_reg)
        BUS_IDLE: begin
          if (take) begin
            bus_reg   <= BUS_DATA;
            addr_reg  <= haddr;
            wr_reg    <= hwrite & (hsize == HSIZE_WORD);
            hreadyout <= 1'b0;
          end
        end
        BUS_DATA: begin
          bus_reg   <= BUS_IDLE;
          hreadyout <= 1'b1;
          hrdata    <= wr_reg ? 32'h0000_0000 : rd_word;
        end
        default: begin
          bus_reg   <= BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // ************************************************************
  // Software registers
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
      sev_reg  <= SEV_RST;
      mask_reg <= MASK_RST;
      stat_reg <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= hwdata[CTRL_W-1:0];
      end
      if (wr_sev) begin
        sev_reg <= hwdata[SEV_W-1:0];
      end
      if (wr_mask) begin
        mask_reg <= hwdata[MASK_W-1:0];
      end
      stat_reg <= stat_next;
    end
  end

  // ************************************************************
  // Error pointers and header logs
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ptr_reg      <= '0;
      ptr_vld_reg  <= 1'b0;
      sptr_reg     <= '0;
      sptr_vld_reg <= 1'b0;
      hdr_reg      <= '0;
      shdr_reg     <= '0;
    end else begin
      if (log_take) begin
        ptr_reg     <= log_ptr;
        ptr_vld_reg <= 1'b1;
        hdr_reg     <= log_hdr;
      end else if (ptr_clr) begin
        ptr_vld_reg <= 1'b0;
      end
      if (s_log) begin
        sptr_reg     <= PTR_W'(ST_PERR);
        sptr_vld_reg <= 1'b1;
        shdr_reg     <= fwd_hdr_reg;
      end else if (sptr_clr) begin
        sptr_vld_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Parity pin filter
  // ************************************************************
  // Stages start at the idle pin level, so no false assertion follows reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      perr_sync_reg  <= '1;
      perr_level_reg <= 1'b0;
    end else begin
      perr_sync_reg  <= {perr_sync_reg[1:0], parity_error_pin_n};
      perr_level_reg <= perr_now;
    end
  end

  // ************************************************************
  // Forwarding state
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fwd_active_reg    <= 1'b0;
      fwd_write_reg     <= 1'b0;
      fwd_hdr_reg       <= '0;
      fwd_parity_invert <= 1'b0;
      fwd_accept        <= 1'b0;
      fwd_drop          <= 1'b0;
    end else begin
      fwd_accept     <= rx_valid & ~rx_crc_err;
      fwd_drop       <= crc;
      // A new packet replaces one that ends in the same cycle
      if (rx_valid & ~rx_crc_err) begin
        fwd_active_reg    <= 1'b1;
        fwd_write_reg     <= rx_is_write;
        fwd_hdr_reg       <= rx_hdr;
        fwd_parity_invert <= rx_poisoned & (rx_is_write | rx_is_rdcpl);
      end else if (fwd_done) begin
        fwd_active_reg    <= 1'b0;
        fwd_parity_invert <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Completion and message outputs
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cpl_valid  <= 1'b0;
      cpl_status <= CPL_SC;
      cpl_poison <= 1'b0;
      msg_valid  <= 1'b0;
      msg_type   <= MSG_NONE;
    end else begin
      cpl_valid <= imm_done;
      if (imm_done) begin
        cpl_status <= imm_status;
        cpl_poison <= imm_poison;
      end
      msg_valid <= (msg_sel != MSG_NONE);
      msg_type  <= msg_sel;
    end
  end

endmodule

// ===== tb/der_pcix_tgt.sv
// Behavioural secondary bus target that takes forwarded transfers
`timescale 1ns/1ps
module der_pcix_tgt #(
  parameter int LEN = 10
) (
  input wire logic ref_clk,            // Core clock
  input wire logic rst,                // Synchronous reset
  input wire logic fwd_accept,         // Transfer starts
  input wire logic perr_cmd,           // Report a parity error
  output logic     fwd_done,           // Transfer finished
  output logic     parity_error_pin_n  // Parity pin, pulled up
);
  int phase;

  // Pin held low three cycles so the synchroniser cannot miss it
  always @(posedge ref_clk) begin
    if (rst) begin
      phase <= 0;
      fwd_done <= 1'b0;
      parity_error_pin_n <= 1'b1;
    end else begin
      fwd_done <= (phase == 1);
      if (fwd_accept)
        phase <= LEN;
      else if (phase > 0)
        phase <= phase - 1;
      parity_error_pin_n <= !(perr_cmd && phase >= LEN - 4 && phase <= LEN - 2);
    end
  end
endmodule

// ===== tb/der_top_props.sv
// Concurrent checks on the ports of the downstream error reporting block
`timescale 1ns/1ps
module der_top_props
  import der_pkg::*;
(
  input wire logic       ref_clk,           // Core clock
  input wire logic       rst,               // Synchronous reset
  input wire logic       rx_valid,          // Received packet
  input wire logic       rx_poisoned,       // Packet poisoned
  input wire logic       rx_crc_err,        // Packet failed CRC
  input wire logic       rx_is_write,       // Write request
  input wire logic       rx_is_rdcpl,       // Read completion
  input wire logic       adv_err,           // Advisory error
  input wire logic       fwd_done,          // Forwarding ended
  input wire logic       imm_done,          // Immediate termination
  input wire logic [1:0] imm_kind,          // Termination kind
  input wire logic       imm_is_read,       // Terminated read
  input wire logic       fwd_accept,        // Forward pulse
  input wire logic       fwd_drop,          // Drop pulse
  input wire logic       fwd_parity_invert, // Parity inversion
  input wire logic       cpl_valid,         // Completion pulse
  input wire logic [2:0] cpl_status,        // Completion status
  input wire logic       cpl_poison,        // Completion poisoned
  input wire logic       msg_valid,         // Message pulse
  input wire logic [1:0] msg_type           // Message kind
);
  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  crc_drop_a: assert property (rx_valid && rx_crc_err |=> fwd_drop && !fwd_accept)
    else $error("CRC failed packet was not dropped");
  clean_fwd_a: assert property (rx_valid && !rx_crc_err |=> fwd_accept && !fwd_drop)
    else $error("Clean packet was not forwarded");
  poison_inv_a: assert property (rx_valid && !rx_crc_err && rx_poisoned
    && (rx_is_write || rx_is_rdcpl) |=> fwd_parity_invert) else $error("Parity not inverted");
  inv_hold_a: assert property (fwd_parity_invert && !fwd_done && !rx_valid |=> fwd_parity_invert)
    else $error("Parity inversion ended early");
  rd_derr_a: assert property (imm_done && imm_kind == IMM_DERR && imm_is_read
    |=> cpl_valid && cpl_status == CPL_SC && cpl_poison) else $error("Bad read error completion");
  wr_derr_a: assert property (imm_done && imm_kind == IMM_DERR && !imm_is_read
    |=> cpl_valid && cpl_status == CPL_UR) else $error("Bad write error completion");
  mabort_cpl_a: assert property (imm_done && imm_kind == IMM_MABORT
    |=> cpl_valid && cpl_status == CPL_UR) else $error("Master abort not mapped to UR");
  tabort_cpl_a: assert property (imm_done && imm_kind == IMM_TABORT
    |=> cpl_valid && cpl_status == CPL_CA) else $error("Target abort not mapped to CA");
  // Parity pin reports never raise a message, so every message has a packet cause
  msg_cause_a: assert property (msg_valid |-> $past(rx_valid) || $past(adv_err))
    else $error("Message without a received error");

  cover property (msg_valid && msg_type == MSG_FTL);
  cover property (fwd_drop);
  cover property (cpl_valid && cpl_poison);
endmodule

bind der_top der_top_props chk_u (.ref_clk, .rst, .rx_valid, .rx_poisoned, .rx_crc_err,
  .rx_is_write, .rx_is_rdcpl, .adv_err, .fwd_done, .imm_done, .imm_kind, .imm_is_read,
  .fwd_accept, .fwd_drop, .fwd_parity_invert, .cpl_valid, .cpl_status, .cpl_poison,
  .msg_valid, .msg_type);

// ===== tb/tb_top.sv
// Self-checking testbench for the downstream error reporting block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_top
  import der_pkg::*;
;
  logic ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0, imm_kind = 0, msg_type;
  logic [2:0] hsize = 0, cpl_status;
  logic [31:0] hwdata = 0, hrdata, rx_hdr = 0, adv_hdr = 0;
  logic rx_valid = 0, rx_poisoned = 0, rx_crc_err = 0, rx_is_write = 0, rx_is_rdcpl = 0;
  logic adv_err = 0, fwd_done, parity_error_pin_n, imm_done = 0, imm_is_read = 0, perr_cmd = 0;
  logic fwd_accept, fwd_drop, fwd_parity_invert, cpl_valid, cpl_poison, msg_valid;
  int err_count = 0, num_checks = 0, cyc = 0, mcount = 0;

  always #50 ref_clk = ~ref_clk;

  der_top dut_u (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
    .hwdata, .hrdata, .hreadyout, .hresp, .rx_valid, .rx_poisoned, .rx_crc_err, .rx_is_write,
    .rx_is_rdcpl, .rx_hdr, .adv_err, .adv_hdr, .fwd_done, .parity_error_pin_n, .imm_done,
    .imm_kind, .imm_is_read, .fwd_accept, .fwd_drop, .fwd_parity_invert, .cpl_valid,
    .cpl_status, .cpl_poison, .msg_valid, .msg_type);
  der_pcix_tgt tgt_u (.ref_clk, .rst, .fwd_accept, .perr_cmd, .fwd_done, .parity_error_pin_n);

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (msg_valid === 1'b1) mcount <= mcount + 1;
    if (cyc == 5000) begin
      err_count++;
      stop_test();
    end
  end

  // ************************************************************
  // Bus and event tasks
  // ************************************************************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a; hsize <= HSIZE_WORD;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    `CHK(nm, {1'b0, e}, {hresp, r})
  endtask

  task automatic run_case(input int k, input logic [5:0] c, input logic [2:0] s,
    input logic [4:0] m, input logic pe, input logic [1:0] em, input logic [11:0] es,
    input logic [15:0] ef);
    logic [31:0] r, h;
    int base;
    h = 32'hA5C3_0000 + num_checks;
    xfer(1'b1, DER_STAT_OFS, 32'h0000_0FFF, r);
    xfer(1'b1, DER_FEP_OFS, 32'h0000_8080, r);
    xfer(1'b1, DER_CTRL_OFS, {26'h0, c}, r);
    xfer(1'b1, DER_SEV_OFS, {29'h0, s}, r);
    xfer(1'b1, DER_MASK_OFS, {27'h0, m}, r);
    perr_cmd <= pe;
    rd(DER_STAT_OFS, 32'h0, "status cleared");
    base = mcount;
    adv_err <= (k == 0); rx_valid <= (k != 0); rx_poisoned <= (k == 1 || k == 2);
    rx_crc_err <= (k == 3); rx_is_write <= (k != 2); rx_is_rdcpl <= (k == 2);
    rx_hdr <= h; adv_hdr <= h;
    @(posedge ref_clk);
    adv_err <= 1'b0; rx_valid <= 1'b0;
    #1;
    `CHK("forward", {k == 3, k == 1 || k == 2, k == 1 || k == 2},
         {fwd_drop, fwd_accept, fwd_parity_invert})
    `CHK("message", {em != 2'h0, em}, {msg_valid, msg_type})
    repeat (16) @(posedge ref_clk);
    `CHK("message count", int'(em != 2'h0), mcount - base)
    rd(DER_STAT_OFS, {20'h0, es}, "status");
    xfer(1'b0, DER_FEP_OFS, 32'h0, r);
    `CHK("pointer valid", ef, r[15:0] & 16'h8080)
    if (ef[7]) `CHK("pointer", (k == 0) ? ST_TLPE : (k == 3) ? ST_ECRC : ST_POISONED_PACKET_STATUS,
                    int'(r[4:0]))
    if (ef[15]) `CHK("secondary pointer", ST_PERR, int'(r[12:8]))
    if (ef[7]) rd(DER_HDR_OFS, h, "header");
    if (ef[15]) rd(DER_SHDR_OFS, h, "secondary header");
    perr_cmd <= 1'b0;
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    logic [31:0] r;
    logic [2:0] es;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 0; a < 32; a += 4) rd(a[7:0], 32'h0, "reset value");
    xfer(1'b1, 8'h1C, 32'hFFFF_FFFF, r);
    rd(8'h1C, 32'h0, "unmapped");
    // Kinds: 0 advisory, 1 poisoned write, 2 poisoned completion, 3 CRC failure
    run_case(0, 6'h08, 3'h0, 5'h00, 0, MSG_COR, 12'h248, 16'h0080);
    run_case(0, 6'h00, 3'h0, 5'h00, 0, MSG_NONE, 12'h248, 16'h0080);
    run_case(0, 6'h08, 3'h0, 5'h08, 0, MSG_NONE, 12'h048, 16'h0000);
    run_case(2, 6'h18, 3'h0, 5'h00, 0, MSG_COR, 12'h0CB, 16'h0080);
    run_case(1, 6'h08, 3'h0, 5'h08, 0, MSG_NONE, 12'h049, 16'h0000);
    run_case(1, 6'h21, 3'h1, 5'h00, 1, MSG_FTL, 12'hC95, 16'h8080);
    run_case(1, 6'h02, 3'h1, 5'h01, 0, MSG_NONE, 12'h091, 16'h0000);
    run_case(3, 6'h01, 3'h2, 5'h00, 0, MSG_FTL, 12'h115, 16'h0080);
    run_case(3, 6'h04, 3'h0, 5'h00, 0, MSG_NFTL, 12'h121, 16'h0080);
    run_case(3, 6'h01, 3'h0, 5'h02, 0, MSG_NONE, 12'h121, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      imm_done <= 1'b1; imm_kind <= k[2:1]; imm_is_read <= k[0];
      @(posedge ref_clk);
      imm_done <= 1'b0;
      #1;
      es = (k[2:1] == 2'h3) ? CPL_CA : (k[2:1] == 2'h2 || k == 2) ? CPL_UR : CPL_SC;
      `CHK("completion", {1'b1, es, k == 3}, {cpl_valid, cpl_status, cpl_poison})
      @(posedge ref_clk);
    end
    stop_test();
  end
endmodule
